// *** rtl/fault_sync.v ***
// Two-flop synchroniser for the raw fault indications
`timescale 1ns/1ps
`default_nettype none
module fault_sync #(
   parameter WIDTH = 3
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Raw and synchronised levels
   input wire [WIDTH-1:0] raw,
   output wire [WIDTH-1:0] synced
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] stable_q;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge mclk) begin
            if (reset) begin
               meta_q[i] <= 1'b0;
               stable_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= raw[i];
               stable_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate
   assign synced = stable_q;
endmodule
`default_nettype wire

// *** rtl/low_dwell_timer.v ***
// Dwell timer that qualifies the output-low condition
`timescale 1ns/1ps
`default_nettype none
module low_dwell_timer #(
   parameter CNT_W = 16,
   parameter integer DWELL_CYCLES = 40000
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Live condition and qualified flag
   input wire below,
   output reg flag_q
);
   localparam [CNT_W-1:0] LIMIT = DWELL_CYCLES[CNT_W-1:0];
   reg [CNT_W-1:0] cnt_q;
   always @(posedge mclk) begin
      if (reset) begin
         cnt_q <= {CNT_W{1'b0}};
         flag_q <= 1'b0;
      end else if (!below) begin
         // Not latched: flag drops with the condition
         cnt_q <= {CNT_W{1'b0}};
         flag_q <= 1'b0;
      end else begin
         if (cnt_q != LIMIT) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         flag_q <= (cnt_q == LIMIT);
      end
   end
endmodule
`default_nettype wire

// *** rtl/regulator_consts.vh ***
// Constants for the regulator fault and status register bank
`ifndef REGULATOR_CONSTS_VH
`define REGULATOR_CONSTS_VH

// Serial bus address byte, write form; bit 0 carries direction
`define SLAVE_ADDR_BYTE 8'h70

// Command codes
`define CMD_CEILING 8'h02
`define CMD_STATUS 8'h04
`define CMD_MASK 8'h05
`define CMD_RAMP 8'h06

// Reset values
`define CEILING_RESET 8'h51
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00
`define RAMP_RESET 8'h04

// Status and mask field positions
`define ST_THERMAL 5
`define ST_LOW 4
`define ST_HIGH 3
`define ST_CURRENT 2
`define ST_CEIL 1
`define ST_ALERT 0

// Analog scaling, for reference by the comparator side
`define CEILING_STEP_MV 10
`define HIGH_MARGIN_MV 300
`define HIGH_FIXED_MV 1830
`define CURRENT_ALARM_MV 23
`define CURRENT_LIMIT_DELTA_MV 15
`define LOW_MARGIN_MV 200

// Output-low dwell time
`define MCLK_MHZ 200
`define LOW_DWELL_US 200
`define LOW_DWELL_CYCLES (`LOW_DWELL_US * `MCLK_MHZ)

`endif

// *** rtl/regulator_fault_status_regs.v ***
// Fault status register bank with two-wire serial slave
//
// Function
// - Ceiling register at 0x02, resets 0x51; bit 7 ignored on write, reads zero.
// - Ceiling code bit 0 is least significant, 10mV per step.
// - Read-only status at 0x04, reads 0x01 after reset, fault bits 5..1, alert bit 0.
// - Output-high flag set from the over-voltage detector indication.
// - Current-alarm flag set from the 23mV valley detector; limit sits 15mV higher.
// - Current-alarm flag sticky; a status read clears it if condition gone.
// - Latched current alarm does not hold alert low after condition ends.
// - All flags except current alarm clear with their live condition.
// - Ceiling-exceeded flag set while target code exceeds ceiling code.
// - Ceiling-exceeded flag clears once target falls to or below ceiling.
// - Status bit 0 is NOR of masked bits 5..1, with live current alarm for bit 2, and drives alert_n.
// - Each fault is ANDed with its inverted mask bit before the NOR.
// - Status flags set regardless of mask; mask only gates the alert.
// - Mask register at 0x05, resets 0x00, bits 5..1 writable, rest zero.
// - Ramp-rate register at 0x06, resets 0x04, all eight bits read back.
// - Device answers only the fixed bus address 70h.
// - Target above ceiling is acknowledged but regulated at the ceiling.
// - Output-low flag only after 200mV-below condition holds 200us.
`include "regulator_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_status_regs #(
   parameter integer LOW_DWELL_CYCLES = `LOW_DWELL_CYCLES,
   parameter LOW_CNT_W = 16
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Serial bus pins, SDA open drain
   input wire scl_in,
   input wire sda_in,
   output reg sda_out_q,
   output reg sda_oe_q,
   // Raw fault indications from the detectors
   input wire thermal_raw,
   input wire output_high_raw,
   input wire output_below_raw,
   input wire current_alarm_raw,
   // Target code from the target-voltage register
   input wire [7:0] target_output_code,
   // Configuration and status toward the regulator
   output reg [6:0] output_ceiling_code_q,
   output reg [7:0] ramp_rate_select_q,
   output reg [7:0] regulated_code_q,
   output reg alert_n_q
);

   // Slave states
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_ADDR_ACK = 4'h2;
   localparam [3:0] ST_CMD = 4'h3;
   localparam [3:0] ST_CMD_ACK = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_WDATA_ACK = 4'h6;
   localparam [3:0] ST_TX = 4'h7;
   localparam [3:0] ST_TX_ACK = 4'h8;
   localparam [3:0] ST_WAIT = 4'h9;

   localparam [3:0] BYTE_BITS = 4'h8;
   localparam [7:0] ADDR_BYTE = `SLAVE_ADDR_BYTE;
   localparam [7:0] CEIL_RST = `CEILING_RESET;
   localparam [7:0] MASK_RST = `MASK_RESET;

   // Bus pin history
   reg scl_q;
   reg sda_q;

   // Slave state
   reg [3:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg [7:0] cmd_q;
   reg read_mode_q;

   // Register contents
   reg [4:0] mask_q;
   reg current_latch_q;
   reg ceiling_exceeded_q;

   // Fault conditions
   wire [2:0] fault_synced;
   wire output_low_fault_flag;
   wire thermal_alarm_flag;
   wire output_high_fault_flag;
   wire current_alarm_live;

   // Bus events
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire byte_done;
   wire wr_en;
   wire tx_load;
   wire status_read;

   // Derived values
   wire [4:0] fault_terms;
   wire [4:0] masked_terms;
   wire alert_summary;
   wire [7:0] status_byte;
   wire [7:0] ceiling_ext;
   reg [7:0] read_byte;

   // Synchronise the detectors before any flag sees them
   fault_sync #(
      .WIDTH(3)
   ) u_fault_sync (
      .mclk(mclk),
      .reset(reset),
      .raw({current_alarm_raw, output_high_raw, thermal_raw}),
      .synced(fault_synced)
   );

   assign thermal_alarm_flag = fault_synced[0];
   assign output_high_fault_flag = fault_synced[1];
   assign current_alarm_live = fault_synced[2];

   // Below-target detector is filtered by the dwell timer
   wire below_synced;
   fault_sync #(
      .WIDTH(1)
   ) u_below_sync (
      .mclk(mclk),
      .reset(reset),
      .raw(output_below_raw),
      .synced(below_synced)
   );

   low_dwell_timer #(
      .CNT_W(LOW_CNT_W),
      .DWELL_CYCLES(LOW_DWELL_CYCLES)
   ) u_low_dwell (
      .mclk(mclk),
      .reset(reset),
      .below(below_synced),
      .flag_q(output_low_fault_flag)
   );

   // Bus edge detection; pins taken as synchronous
   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
   assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;
   assign byte_done = scl_fall & (bit_cnt_q == BYTE_BITS);

   // Data byte commits on its eighth falling clock
   assign wr_en = (state_q == ST_WDATA) & byte_done & ~bus_start & ~bus_stop;

   // A byte is loaded for transmission
   assign tx_load = ~bus_start & ~bus_stop & scl_fall &
                    (((state_q == ST_ADDR_ACK) & read_mode_q) |
                     (state_q == ST_TX_ACK));
   assign status_read = tx_load & (cmd_q == `CMD_STATUS);

   // Fault terms in status bit order 5..1
   assign fault_terms = {thermal_alarm_flag, output_low_fault_flag,
                         output_high_fault_flag, current_alarm_live,
                         ceiling_exceeded_q};

   // Live current condition gates the alert, not the latch
   assign masked_terms = fault_terms & ~mask_q;
   assign alert_summary = ~(|masked_terms);

   assign status_byte = {2'b00,
                         thermal_alarm_flag,
                         output_low_fault_flag,
                         output_high_fault_flag,
                         current_latch_q,
                         ceiling_exceeded_q,
                         alert_summary};

   assign ceiling_ext = {1'b0, output_ceiling_code_q};

   // Read data selection; unmapped commands read zero
   always @* begin
      if (cmd_q == `CMD_CEILING) begin
         read_byte = ceiling_ext;
      end else if (cmd_q == `CMD_STATUS) begin
         read_byte = status_byte;
      end else if (cmd_q == `CMD_MASK) begin
         read_byte = {2'b00, mask_q, 1'b0};
      end else if (cmd_q == `CMD_RAMP) begin
         read_byte = ramp_rate_select_q;
      end else begin
         read_byte = 8'h00;
      end
   end

   // Serial slave engine
   always @(posedge mclk) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         cmd_q <= 8'h00;
         read_mode_q <= 1'b0;
         sda_oe_q <= 1'b0;
         sda_out_q <= 1'b0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         // Open drain: only ever pulls low
         sda_out_q <= 1'b0;
         if (bus_start) begin
            // Repeated start keeps the command pointer
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (bus_stop) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else begin
            case (state_q)
               ST_ADDR, ST_CMD, ST_WDATA: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_in};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (byte_done) begin
                     bit_cnt_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        if (shift_q[7:1] == ADDR_BYTE[7:1]) begin
                           read_mode_q <= shift_q[0];
                           sda_oe_q <= 1'b1;
                           state_q <= ST_ADDR_ACK;
                        end else begin
                           // Other addresses: stay off the bus until the next start or stop
                           state_q <= ST_WAIT;
                        end
                     end else if (state_q == ST_CMD) begin
                        cmd_q <= shift_q;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_CMD_ACK;
                     end else begin
                        // Every data byte acknowledged, over-ceiling ones too
                        sda_oe_q <= 1'b1;
                        state_q <= ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (read_mode_q) begin
                        shift_q <= read_byte;
                        sda_oe_q <= ~read_byte[7];
                        state_q <= ST_TX;
                     end else begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_CMD;
                     end
                  end
               end
               ST_CMD_ACK, ST_WDATA_ACK: begin
                  if (scl_fall) begin
                     // Further bytes rewrite the same register
                     sda_oe_q <= 1'b0;
                     state_q <= ST_WDATA;
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_q == BYTE_BITS) begin
                        bit_cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        state_q <= ST_TX_ACK;
                     end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_q <= ~shift_q[6];
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise && sda_in) begin
                     // Master refused: done until the next start or stop
                     state_q <= ST_WAIT;
                  end else if (scl_fall) begin
                     shift_q <= read_byte;
                     sda_oe_q <= ~read_byte[7];
                     state_q <= ST_TX;
                  end
               end
               ST_WAIT: begin
                  sda_oe_q <= 1'b0;
               end
               default: begin
                  sda_oe_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Writable registers
   always @(posedge mclk) begin
      if (reset) begin
         output_ceiling_code_q <= CEIL_RST[6:0];
         mask_q <= MASK_RST[`ST_THERMAL:`ST_CEIL];
         ramp_rate_select_q <= `RAMP_RESET;
      end else if (wr_en) begin
         if (cmd_q == `CMD_CEILING) begin
            // Bit 7 accepted but dropped
            output_ceiling_code_q <= shift_q[6:0];
         end else if (cmd_q == `CMD_MASK) begin
            mask_q <= shift_q[`ST_THERMAL:`ST_CEIL];
         end else if (cmd_q == `CMD_RAMP) begin
            ramp_rate_select_q <= shift_q;
         end
      end
   end

   // Fault flags and alert
   always @(posedge mclk) begin
      if (reset) begin
         current_latch_q <= 1'b0;
         ceiling_exceeded_q <= 1'b0;
         regulated_code_q <= 8'h00;
         alert_n_q <= 1'b1;
      end else begin
         // Set wins over a read clear in the same cycle
         current_latch_q <= current_alarm_live |
                            (current_latch_q & ~status_read);
         ceiling_exceeded_q <= (target_output_code > ceiling_ext);
         if (target_output_code > ceiling_ext) begin
            regulated_code_q <= ceiling_ext;
         end else begin
            regulated_code_q <= target_output_code;
         end
         alert_n_q <= alert_summary;
      end
   end

endmodule
`default_nettype wire

// *** verification/regulator_bus_master.sv ***
// Serial bus master model driving the register bank pins
`timescale 1ns/1ps
`default_nettype none
module regulator_bus_master (
   // Clock
   input wire logic mclk,
   // Pins
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   localparam logic [7:0] ADDR_W = 8'h70;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Three cycles a phase keeps clear of the two-sample minimum
   task automatic ph;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic start;
      sda = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      sda = 1'b0;
      ph;
      scl = 1'b0;
      ph;
   endtask
   task automatic stop;
      sda = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      sda = 1'b1;
      ph;
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda = b;
      ph;
      scl = 1'b1;
      ph;
      r = sda_line;
      scl = 1'b0;
      ph;
   endtask
   // Released bits read back what the device drives
   task automatic byte_io(input logic [7:0] w, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], r[i]);
      end
      bit_io(1'b1, a);
      ack = ~a;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic k0, k1, k2;
      start;
      byte_io(a, r, k0);
      byte_io(c, r, k1);
      byte_io(d, r, k2);
      stop;
      ok = k0 & k1 & k2;
   endtask
   // Last byte ends with a not-acknowledge
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      logic [7:0] r;
      logic k;
      start;
      byte_io(ADDR_W, r, k);
      byte_io(c, r, k);
      start;
      byte_io(ADDR_W | 8'h01, r, k);
      byte_io(8'hff, d, k);
      stop;
   endtask
endmodule
`default_nettype wire

// *** verification/regulator_fault_status_regs_asserts.sv ***
// Assertion checker for the fault status register bank
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_status_regs_asserts #(
   parameter integer LOW_DWELL_CYCLES = 40000,
   parameter LOW_CNT_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_out_q,
   input wire logic sda_oe_q,
   // Fault inputs
   input wire logic thermal_raw,
   input wire logic output_high_raw,
   input wire logic output_below_raw,
   input wire logic current_alarm_raw,
   input wire logic [7:0] target_output_code,
   // Outputs
   input wire logic [6:0] output_ceiling_code_q,
   input wire logic [7:0] ramp_rate_select_q,
   input wire logic [7:0] regulated_code_q,
   input wire logic alert_n_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire [7:0] ceil_w = {1'b0, output_ceiling_code_q};
   wire [7:0] clamp_w = (target_output_code > ceil_w) ? ceil_w : target_output_code;
   wire cause_w = thermal_raw | output_high_raw | current_alarm_raw | (target_output_code > ceil_w);
   logic [7:0] oth_idle_q;
   logic [7:0] blw_idle_q;
   logic [31:0] blw_run_q;
   // Saturating so long quiet spells never wrap back into the window
   always @(posedge mclk) begin
      if (reset) begin
         oth_idle_q <= 8'h00;
         blw_idle_q <= 8'h00;
         blw_run_q <= 32'h0000_0000;
      end else begin
         oth_idle_q <= cause_w ? 8'h00 : oth_idle_q + {7'h00, oth_idle_q != 8'hff};
         blw_idle_q <= output_below_raw ? 8'h00 : blw_idle_q + {7'h00, blw_idle_q != 8'hff};
         blw_run_q <= output_below_raw ? blw_run_q + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   a_sda_out_low: assert property (sda_out_q == 1'b0)
      else $error("data pin driven high");
   a_reset_values: assert property ($fell(reset) |->
      output_ceiling_code_q == 7'h51 && ramp_rate_select_q == 8'h04 && alert_n_q && !sda_oe_q)
      else $error("wrong value after reset");
   a_clamp_follow: assert property ($stable(clamp_w)[*2] |-> regulated_code_q == clamp_w)
      else $error("regulated code not clamped to ceiling");
   a_alert_release: assert property ((oth_idle_q >= 8'h06 && blw_idle_q >= 8'h06) |-> alert_n_q)
      else $error("alert held without a live fault");
   a_low_dwell_min: assert property ((oth_idle_q >= 8'h06 && !alert_n_q) |->
      (blw_run_q > LOW_DWELL_CYCLES) || (blw_idle_q < 8'h06))
      else $error("output low alert before dwell");
   a_oe_scl_low: assert property ($changed(sda_oe_q) |-> !scl_in)
      else $error("data pin changed while clock high");
   a_ceil_write: assert property ($changed(output_ceiling_code_q) |-> !scl_in)
      else $error("ceiling changed outside a write");
   a_ramp_write: assert property ($changed(ramp_rate_select_q) |-> !scl_in)
      else $error("ramp changed outside a write");
   c_alert_fall: cover property ($fell(alert_n_q));
   c_ack_drive: cover property ($rose(sda_oe_q));
   c_ceil_change: cover property ($changed(output_ceiling_code_q));
endmodule
`default_nettype wire

// *** verification/tb_regulator_fault_status_regs.sv ***
// Self-checking bench for the fault status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_regulator_fault_status_regs;
   localparam integer DWELL = 20;
   logic mclk, reset, scl, sda_m, sda_oe_q, sda_out_q;
   logic th, hi, lo, cur_al, alert_n_q, ok;
   logic [7:0] tgt, ramp, regd;
   logic [6:0] ceil;
   int err_count, comparisons;
   logic [7:0] wc[4] = '{8'h02, 8'h06, 8'h05, 8'h03};
   logic [7:0] wd[4] = '{8'hff, 8'hc9, 8'hff, 8'h55};
   logic [7:0] we[4] = '{8'h7f, 8'hc9, 8'h3e, 8'h00};
   // Open drain with pull-up
   wire sda_w = sda_m & ~sda_oe_q;
   regulator_fault_status_regs #(.LOW_DWELL_CYCLES(DWELL), .LOW_CNT_W(16)) dut (
      .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda_w),
      .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .thermal_raw(th),
      .output_high_raw(hi), .output_below_raw(lo), .current_alarm_raw(cur_al),
      .target_output_code(tgt), .output_ceiling_code_q(ceil),
      .ramp_rate_select_q(ramp), .regulated_code_q(regd), .alert_n_q(alert_n_q)
   );
   regulator_bus_master m (.mclk(mclk), .sda_line(sda_w), .scl(scl), .sda(sda_m));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] c, input logic [7:0] e);
      logic [7:0] d;
      m.rd(c, d);
      chk("register read", e, d);
   endtask
   task automatic achk(input logic e);
      chk("alert", {7'h00, e}, {7'h00, alert_n_q});
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      {th, hi, lo, cur_al} = 4'h0;
      tgt = 8'h33;
      tick(8);
      reset = 1'b0;
      tick(2);
      rchk(8'h02, 8'h51);
      rchk(8'h05, 8'h00);
      rchk(8'h06, 8'h04);
      rchk(8'h04, 8'h01);
      for (int i = 0; i < 4; i++) begin
         m.wr(8'h70, wc[i], wd[i], ok);
         chk("ack", 8'h01, {7'h00, ok});
         rchk(wc[i], we[i]);
      end
      chk("ceiling port", 8'h7f, {1'b0, ceil});
      chk("ramp port", 8'hc9, ramp);
      m.wr(8'h72, 8'h06, 8'h11, ok);
      chk("foreign ack", 8'h00, {7'h00, ok});
      rchk(8'h06, 8'hc9);
      th = 1'b1;
      tick(8);
      achk(1'b1);
      rchk(8'h04, 8'h21);
      th = 1'b0;
      m.wr(8'h70, 8'h05, 8'h00, ok);
      for (int i = 0; i < 2; i++) begin
         {th, hi} = i ? 2'b01 : 2'b10;
         tick(8);
         achk(1'b0);
         rchk(8'h04, i ? 8'h08 : 8'h20);
         {th, hi} = 2'b00;
         tick(8);
         rchk(8'h04, 8'h01);
      end
      cur_al = 1'b1;
      tick(8);
      achk(1'b0);
      cur_al = 1'b0;
      tick(8);
      achk(1'b1);
      rchk(8'h04, 8'h05);
      rchk(8'h04, 8'h01);
      cur_al = 1'b1;
      tick(8);
      rchk(8'h04, 8'h04);
      rchk(8'h04, 8'h04);
      cur_al = 1'b0;
      tick(8);
      rchk(8'h04, 8'h05);
      m.wr(8'h70, 8'h02, 8'h40, ok);
      tgt = 8'h41;
      tick(8);
      chk("regulated", 8'h40, regd);
      achk(1'b0);
      rchk(8'h04, 8'h02);
      tgt = 8'h3f;
      tick(8);
      chk("regulated", 8'h3f, regd);
      rchk(8'h04, 8'h01);
      lo = 1'b1;
      tick(DWELL - 4);
      achk(1'b1);
      for (int n = 0; n < 100 && alert_n_q; n++) tick(1);
      achk(1'b0);
      // A stuck alert would leave the rest meaningless
      if (alert_n_q === 1'b0) begin
         rchk(8'h04, 8'h10);
         lo = 1'b0;
         tick(8);
         achk(1'b1);
         reset = 1'b1;
         tick(8);
         reset = 1'b0;
         tick(2);
         rchk(8'h02, 8'h51);
         rchk(8'h05, 8'h00);
      end
      complete_run;
   end
endmodule
bind regulator_fault_status_regs regulator_fault_status_regs_asserts #(
   .LOW_DWELL_CYCLES(LOW_DWELL_CYCLES), .LOW_CNT_W(LOW_CNT_W)
) chk_i (
   .mclk(mclk), .reset(reset), .scl_in(scl_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
   .thermal_raw(thermal_raw), .output_high_raw(output_high_raw), .output_below_raw(output_below_raw),
   .current_alarm_raw(current_alarm_raw), .target_output_code(target_output_code),
   .output_ceiling_code_q(output_ceiling_code_q), .ramp_rate_select_q(ramp_rate_select_q),
   .regulated_code_q(regulated_code_q), .alert_n_q(alert_n_q)
);
`default_nettype wire
